// File: lpcs_pkg.sv
// Package with register map, field layout and timing constants of the low-power calibration scheduler.
//
// How it works
// - Trigger source select 0 makes the software trigger bit the calibration trigger.
// - Sleep code sets sleep to (2^E+1)x256 sample clocks, E from a code table.
// - Timed sleep applies only with low-power enabled and wake-on-trigger cleared.
// - After waking, wait (2^E+1)x256 clocks before calibrating, E from settle table.
// - Wake-on-trigger 0 runs autonomously with sleep set by the sleep code.
// - Wake-on-trigger 1 sleeps until the selected trigger is low, then wakes.
// - Low-power enable acts only when background calibration is enabled; resets to 0.
// - Vector access enable bit 0 opens reads and writes through the data port.
// - Trigger source select 1 uses the external pin and ignores the software bit.
package lpcs_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] LPCS_ADDR_SOFT_TRIG = 8'h6c;
    localparam logic [7:0] LPCS_ADDR_LP_CFG    = 8'h6e;
    localparam logic [7:0] LPCS_ADDR_VEC_EN    = 8'h70;
    localparam logic [7:0] LPCS_ADDR_CAL_DATA  = 8'h71;
    localparam logic [7:0] LPCS_ADDR_CTRL      = 8'h80;
    localparam logic [7:0] LPCS_ADDR_STATUS    = 8'h81;

    localparam logic [7:0] LPCS_RST_SOFT_TRIG = 8'h01;
    localparam logic [7:0] LPCS_RST_LP_CFG    = 8'h88;
    localparam logic [7:0] LPCS_RST_VEC_EN    = 8'h00;
    localparam logic [7:0] LPCS_RST_CTRL      = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int LPCS_LOW_POWER_CAL_ENABLE_BIT    = 0;
    localparam int LPCS_WAKE_ON_TRIGGER_BIT  = 1;
    localparam int LPCS_WAKE_LSB     = 3;
    localparam int LPCS_SLEEP_LSB    = 5;
    localparam int LPCS_SOFT_BIT     = 0;
    localparam int LPCS_VEC_EN_BIT   = 0;
    localparam int LPCS_SRC_SEL_BIT  = 0;
    localparam int LPCS_BG_EN_BIT    = 1;
    localparam int LPCS_HALT_BIT     = 2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          LPCS_CNT_W     = 42;
    localparam int          LPCS_UNIT_LOG2 = 8;
    localparam int          LPCS_VEC_LEN   = 673;
    localparam logic [9:0]  LPCS_VEC_LAST  = 10'(LPCS_VEC_LEN - 1);
    localparam logic [7:0]  LPCS_CAL_CYCLES = 8'h40;

    typedef enum logic [2:0] {
        LPCS_IDLE   = 3'b000,
        LPCS_SLEEP  = 3'b001,
        LPCS_SETTLE = 3'b011,
        LPCS_CAL    = 3'b010,
        LPCS_HALTED = 3'b110
    } lpcs_state_t;

    // Exponent of the sleep interval for each code.
    function automatic logic [5:0] lpcs_sleep_exp(input logic [2:0] code);
        logic [5:0] e;
        e = 6'h03;
        case (code)
            3'h1: e = 6'h0f;
            3'h2: e = 6'h12;
            3'h3: e = 6'h15;
            3'h4: e = 6'h18;
            3'h5: e = 6'h1b;
            3'h6: e = 6'h1e;
            3'h7: e = 6'h21;
            default: e = 6'h03;
        endcase
        return e;
    endfunction

    // Exponent of the wake settle interval for each code.
    function automatic logic [5:0] lpcs_wake_exp(input logic [1:0] code);
        logic [5:0] e;
        e = 6'h03;
        case (code)
            2'h1: e = 6'h12;
            2'h2: e = 6'h15;
            2'h3: e = 6'h18;
            default: e = 6'h03;
        endcase
        return e;
    endfunction

    // Interval (2^E+1)x256 in sample clock periods.
    function automatic logic [LPCS_CNT_W-1:0] lpcs_interval(input logic [5:0] e);
        logic [LPCS_CNT_W-1:0] one;
        one = LPCS_CNT_W'(1);
        return ((one << e) + one) << LPCS_UNIT_LOG2;
    endfunction
endpackage

// File: lpcs_vec_mem.sv
// Calibration vector store with registered read data.
`timescale 1ns/1ps
`default_nettype none
module lpcs_vec_mem
    import lpcs_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Access
    input  wire logic [9:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output var  logic [7:0] rd_data
);
    logic [7:0] mem [0:LPCS_VEC_LEN-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule
`default_nettype wire

// File: lpcs_top.sv
// Low-power background calibration scheduler with register port and vector access.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lpcs_top
    import lpcs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // Trigger pin
    input  wire logic       cal_trigger_pin,
    // Core control
    output var  logic       core_sleep,
    output var  logic       core_cal,
    output var  logic       cal_halted
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]            soft_q;
    logic [7:0]            lp_q;
    logic [7:0]            vec_en_q;
    logic [7:0]            ctrl_q;
    logic [9:0]            vec_ptr_q;
    logic [9:0]            vec_ptr_d;
    logic [7:0]            rdata_q;
    logic [7:0]            rdata_d;
    logic                  data_rd_q;
    logic                  data_rd_d;
    logic [7:0]            mem_rdata;
    lpcs_state_t           state_q;
    logic [LPCS_CNT_W-1:0] cnt_q;
    logic [7:0]            cal_cnt_q;

    wire       wr_soft  = reg_wr && (reg_addr == LPCS_ADDR_SOFT_TRIG);
    wire       wr_lp    = reg_wr && (reg_addr == LPCS_ADDR_LP_CFG);
    wire       wr_vec   = reg_wr && (reg_addr == LPCS_ADDR_VEC_EN);
    wire       wr_ctrl  = reg_wr && (reg_addr == LPCS_ADDR_CTRL);
    wire       vec_open = vec_en_q[LPCS_VEC_EN_BIT];
    wire       data_acc = vec_open && (reg_addr == LPCS_ADDR_CAL_DATA) && (reg_wr || reg_rd);

    always_ff @(posedge clk) begin
        if (srst) begin
            soft_q   <= LPCS_RST_SOFT_TRIG;
            lp_q     <= LPCS_RST_LP_CFG;
            vec_en_q <= LPCS_RST_VEC_EN;
            ctrl_q   <= LPCS_RST_CTRL;
        end else begin
            if (wr_soft) begin
                soft_q <= reg_wdata;
            end
            if (wr_lp) begin
                lp_q <= reg_wdata;
            end
            if (wr_vec) begin
                vec_en_q <= reg_wdata;
            end
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // Trigger selection and mode decode
    // ****************************************************************
    // The trigger is active low: a core sleeping with wake-on-trigger set wakes when it sees 0.
    wire trig = ctrl_q[LPCS_SRC_SEL_BIT] ? cal_trigger_pin
                                         : soft_q[LPCS_SOFT_BIT];
    wire lp_active = lp_q[LPCS_LOW_POWER_CAL_ENABLE_BIT] && ctrl_q[LPCS_BG_EN_BIT];
    wire on_trig   = lp_q[LPCS_WAKE_ON_TRIGGER_BIT];
    wire [LPCS_CNT_W-1:0] sleep_len =
        lpcs_interval(lpcs_sleep_exp(lp_q[LPCS_SLEEP_LSB +: 3]));
    wire [LPCS_CNT_W-1:0] wake_len =
        lpcs_interval(lpcs_wake_exp(lp_q[LPCS_WAKE_LSB +: 2]));
    wire halt_req = ctrl_q[LPCS_HALT_BIT];

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Counters load length minus one so each phase lasts exactly its interval.
    // Calibration itself is modelled as a fixed burst; the real routine lives elsewhere.
    // A halt request is taken only between bursts, so a running calibration is never cut short.
    // Leaving low-power mode drops back to idle at once; only a burst already running finishes.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q   <= LPCS_IDLE;
            cnt_q     <= '0;
            cal_cnt_q <= '0;
        end else begin
            case (state_q)
                LPCS_IDLE: begin
                    if (halt_req) begin
                        state_q <= LPCS_HALTED;
                    end else if (lp_active) begin
                        state_q <= LPCS_SLEEP;
                        cnt_q   <= sleep_len - LPCS_CNT_W'(1);
                    end
                end
                LPCS_SLEEP: begin
                    if (!lp_active) begin
                        state_q <= LPCS_IDLE;
                    end else if (on_trig ? !trig : (cnt_q == '0)) begin
                        state_q <= LPCS_SETTLE;
                        cnt_q   <= wake_len - LPCS_CNT_W'(1);
                    end else if (!on_trig) begin
                        cnt_q <= cnt_q - LPCS_CNT_W'(1);
                    end
                end
                LPCS_SETTLE: begin
                    if (!lp_active) begin
                        state_q <= LPCS_IDLE;
                    end else if (cnt_q == '0) begin
                        state_q   <= LPCS_CAL;
                        cal_cnt_q <= LPCS_CAL_CYCLES - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - LPCS_CNT_W'(1);
                    end
                end
                LPCS_CAL: begin
                    if (cal_cnt_q == 8'h00) begin
                        state_q <= halt_req ? LPCS_HALTED : LPCS_IDLE;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 8'h01;
                    end
                end
                LPCS_HALTED: begin
                    if (!halt_req) begin
                        state_q <= LPCS_IDLE;
                    end
                end
                default: state_q <= LPCS_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Core control outputs
    // ****************************************************************
    // Outputs follow the state one cycle late so that each one comes from a flop.
    always_ff @(posedge clk) begin
        if (srst) begin
            core_sleep <= 1'b0;
            core_cal   <= 1'b0;
            cal_halted <= 1'b0;
        end else begin
            core_sleep <= (state_q == LPCS_SLEEP);
            core_cal   <= (state_q == LPCS_CAL);
            cal_halted <= (state_q == LPCS_HALTED);
        end
    end

    // ****************************************************************
    // Calibration vector port
    // ****************************************************************
    // The pointer wraps after a full vector so the next transfer starts clean.
    always_comb begin
        vec_ptr_d = vec_ptr_q;
        if (!vec_open) begin
            vec_ptr_d = '0;
        end else if (data_acc) begin
            vec_ptr_d = (vec_ptr_q == LPCS_VEC_LAST) ? 10'h000 : vec_ptr_q + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            vec_ptr_q <= '0;
        end else begin
            vec_ptr_q <= vec_ptr_d;
        end
    end

    lpcs_vec_mem u_mem (
        .clk     (clk),
        .addr    (vec_ptr_q),
        .wr_en   (data_acc && reg_wr),
        .wr_data (reg_wdata),
        .rd_data (mem_rdata)
    );

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Vector reads take the store's own output flop, so they answer in the same cycle as the others.
    // A closed vector port answers 0, like an unmapped address.
    always_comb begin
        rdata_d   = 8'h00;
        data_rd_d = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                LPCS_ADDR_SOFT_TRIG: rdata_d = soft_q;
                LPCS_ADDR_LP_CFG:    rdata_d = lp_q;
                LPCS_ADDR_VEC_EN:    rdata_d = vec_en_q;
                LPCS_ADDR_CTRL:      rdata_d = ctrl_q;
                LPCS_ADDR_STATUS:    rdata_d = {5'h00, state_q};
                LPCS_ADDR_CAL_DATA:  data_rd_d = vec_open;
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q   <= 8'h00;
            data_rd_q <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            data_rd_q <= data_rd_d;
        end
    end

    assign reg_rdata = data_rd_q ? mem_rdata : rdata_q;
endmodule
`default_nettype wire

// File: lpcs_top_asserts.sv
// Checker of the scheduler's port behaviour.
`timescale 1ns/1ps
`default_nettype none
module lpcs_top_asserts
    import lpcs_pkg::*;
(
    // Clock, reset and register port
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Trigger and core control
    input wire logic       cal_trigger_pin,
    input wire logic       core_sleep,
    input wire logic       core_cal,
    input wire logic       cal_halted
);
    // ****
    // Shadows and counters
    // ****
    logic [7:0]  cfg_q, ctrl_q, soft_q;
    logic [15:0] slp_n, gap_n, cal_n;
    logic [2:0]  off_n;
    wire         lp_on = ctrl_q[1] & cfg_q[0];
    wire         tmode = lp_on & cfg_q[1];
    wire         trig = ctrl_q[0] ? cal_trigger_pin : soft_q[0];
    // Shadows follow writes only, so a register that never updates shows up.
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= LPCS_RST_LP_CFG;
            ctrl_q <= LPCS_RST_CTRL;
            soft_q <= LPCS_RST_SOFT_TRIG;
        end else if (reg_wr) begin
            if (reg_addr == LPCS_ADDR_LP_CFG) cfg_q <= reg_wdata;
            if (reg_addr == LPCS_ADDR_CTRL) ctrl_q <= reg_wdata;
            if (reg_addr == LPCS_ADDR_SOFT_TRIG) soft_q <= reg_wdata;
        end
    end
    always_ff @(posedge clk) begin
        slp_n <= (srst || !core_sleep) ? 16'h0000 : slp_n + 16'h0001;
        cal_n <= (srst || !core_cal) ? 16'h0000 : cal_n + 16'h0001;
        gap_n <= (srst || core_sleep || core_cal) ? 16'h0000 : gap_n + 16'h0001;
        off_n <= (srst || lp_on) ? 3'h0 : off_n + {2'h0, off_n != 3'h7};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_quiet: assert property (
        $fell(srst) |-> !core_sleep && !core_cal && !cal_halted) else $error("active after reset");
    a_lp_inactive: assert property (
        off_n == 3'h7 |-> !core_sleep && !core_cal) else $error("low-power active while off");
    a_sleep_len: assert property (
        $fell(core_sleep) && lp_on && !cfg_q[1] && cfg_q[7:5] == 3'h0 |-> slp_n == 16'h0900)
        else $error("sleep length");
    a_settle_len: assert property (
        $rose(core_cal) && cfg_q[0] && cfg_q[4:3] == 2'h0 |-> gap_n == 16'h0900) else $error("settle length");
    a_cal_len: assert property (
        $fell(core_cal) |-> cal_n == 16'h0040) else $error("calibration length");
    a_cfg_readback: assert property (
        reg_rd && reg_addr == LPCS_ADDR_LP_CFG |=> reg_rdata == cfg_q) else $error("config readback");
    a_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {8'h6c, 8'h6e, 8'h70, 8'h71, 8'h80, 8'h81}) |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    a_trig_hold: assert property (
        tmode && $past(tmode, 2) && core_sleep && trig && $past(trig) && $past(trig, 2) |=> core_sleep)
        else $error("woke without trigger");
    a_trig_wake: assert property (
        tmode && core_sleep && !trig |-> ##[1:4] !core_sleep) else $error("no wake on trigger");
endmodule
`default_nettype wire

// File: lpcs_trig_model.sv
// Model of the logic that drives the external calibration trigger pin.
`timescale 1ns/1ps
`default_nettype none
module lpcs_trig_model #(
    parameter int DLY = 3,
    parameter int LEN = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Request and pin
    input  wire logic pull,
    output wire logic pin
);
    int n_q;
    // A larger DLY gives a slow answer; the low pulse lasts LEN cycles.
    always_ff @(posedge clk) begin
        if (srst || n_q >= DLY + LEN)
            n_q <= 0;
        else if (n_q != 0 || pull)
            n_q <= n_q + 1;
    end
    // Held high outside a pulse, so no trigger is raised by default.
    assign pin = !(n_q > DLY);
endmodule
`default_nettype wire

// File: tb_lowpower_cal_scheduler.sv
// Self-checking testbench of the low-power calibration scheduler.
`timescale 1ns/1ps
`default_nettype none
module tb_lowpower_cal_scheduler;
    import lpcs_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pull = 1'b0, pin;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic        core_sleep, core_cal, cal_halted;
    logic [15:0] d;
    int          miscompares = 0, n_tests = 0, n;
    always #2 clk = ~clk;
    lpcs_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_trigger_pin(pin), .core_sleep(core_sleep),
        .core_cal(core_cal), .cal_halted(cal_halted));
    lpcs_trig_model #(.DLY(3), .LEN(8)) far (.clk(clk), .srst(srst), .pull(pull), .pin(pin));
    // ****
    // Shared tasks
    // ****
    task end_of_test;
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = {8'h00, reg_rdata};
    endtask
    // Waits for output w (0 sleep, 1 calibrate, 2 halted) to reach lvl; c counts cycles.
    task wt(input int w, input logic lvl, input int lim, output int c);
        c = 0;
        while ((w == 0 ? core_sleep : w == 1 ? core_cal : cal_halted) !== lvl) begin
            @(posedge clk);
            #1 c++;
            if (c > lim) begin
                chk(16'(c), 16'(lim));
                end_of_test;
            end
        end
    endtask
    task hold_asleep;
        n = 0;
        repeat (3000) begin
            @(posedge clk);
            #1 n += int'(core_sleep === 1'b1);
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_regs;
        rd(LPCS_ADDR_SOFT_TRIG, d); chk(d, 16'h0001);
        rd(LPCS_ADDR_LP_CFG, d); chk(d, 16'h0088);
        rd(LPCS_ADDR_VEC_EN, d); chk(d, 16'h0000);
        rd(8'h55, d); chk(d, 16'h0000);
    endtask
    task t_vec;
        wr(LPCS_ADDR_CAL_DATA, 8'h3c);
        rd(LPCS_ADDR_CAL_DATA, d); chk(d, 16'h0000);
        wr(LPCS_ADDR_CTRL, 8'h04);
        wt(2, 1'b1, 20, n);
        rd(LPCS_ADDR_STATUS, d); chk(d, 16'h0006);
        wr(LPCS_ADDR_VEC_EN, 8'h01);
        for (int i = 0; i < LPCS_VEC_LEN; i++) wr(LPCS_ADDR_CAL_DATA, 8'(i * 7 + 1));
        wr(LPCS_ADDR_VEC_EN, 8'h00);
        wr(LPCS_ADDR_VEC_EN, 8'h01);
        for (int i = 0; i <= LPCS_VEC_LEN; i++) begin
            rd(LPCS_ADDR_CAL_DATA, d);
            chk(d, {8'h00, 8'((i % LPCS_VEC_LEN) * 7 + 1)});
        end
        wr(LPCS_ADDR_VEC_EN, 8'h00);
        wr(LPCS_ADDR_CTRL, 8'h00);
        wt(2, 1'b0, 20, n);
    endtask
    task t_timed;
        wr(LPCS_ADDR_LP_CFG, 8'h01);
        repeat (20) @(posedge clk);
        #1 chk({15'h0000, core_sleep}, 16'h0000);
        wr(LPCS_ADDR_CTRL, 8'h02);
        wt(0, 1'b1, 10, n);
        wt(0, 1'b0, 3000, n); chk(16'(n), 16'h0900);
        wt(1, 1'b1, 3000, n); chk(16'(n), 16'h0900);
        wt(1, 1'b0, 100, n); chk(16'(n), 16'h0040);
        wt(0, 1'b1, 4, n);
    endtask
    task t_trig;
        wr(LPCS_ADDR_LP_CFG, 8'h83);
        hold_asleep; chk(16'(n), 16'h0bb8);
        wr(LPCS_ADDR_SOFT_TRIG, 8'h00);
        wt(0, 1'b0, 6, n);
        wr(LPCS_ADDR_SOFT_TRIG, 8'h01);
        wt(0, 1'b1, 3000, n);
        wr(LPCS_ADDR_CTRL, 8'h03);
        wr(LPCS_ADDR_SOFT_TRIG, 8'h00);
        hold_asleep; chk(16'(n), 16'h0bb8);
        wr(LPCS_ADDR_LP_CFG, 8'h8b);
        @(posedge clk) pull <= 1'b1;
        @(posedge clk) pull <= 1'b0;
        #1 wt(0, 1'b0, 16, n);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1 t_regs;
        t_vec;
        t_timed;
        t_trig;
        end_of_test;
    end
endmodule
bind lpcs_top lpcs_top_asserts chk_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_trigger_pin(cal_trigger_pin),
    .core_sleep(core_sleep), .core_cal(core_cal), .cal_halted(cal_halted));
`default_nettype wire
